//--- hw/hwlmd_defs.svh
`ifndef HWLMD_DEFS_SVH
`define HWLMD_DEFS_SVH
// ----------------------------------------
// opcodes of the load group
// ----------------------------------------
`define HWLMD_OP_HALF_S 6'h0F
`define HWLMD_OP_HALF_S_IO 6'h2F
`define HWLMD_OP_HALF_U 6'h0B
`define HWLMD_OP_HALF_U_IO 6'h2B
`define HWLMD_OP_WORD 6'h17
`define HWLMD_OP_WORD_IO 6'h37
// ----------------------------------------
// instruction field positions
// ----------------------------------------
`define HWLMD_A_MSB 31
`define HWLMD_A_LSB 27
`define HWLMD_B_MSB 26
`define HWLMD_B_LSB 22
`define HWLMD_C_MSB 21
`define HWLMD_C_LSB 17
`define HWLMD_IMM_MSB 21
`define HWLMD_IMM_LSB 6
`define HWLMD_OPX_MSB 16
`define HWLMD_OPX_LSB 11
`define HWLMD_OP_MSB 5
`define HWLMD_OP_LSB 0
// ----------------------------------------
// fixed values
// ----------------------------------------
`define HWLMD_ZERO_REG 5'h00
`define HWLMD_ZERO_HALF 16'h0000
`define HWLMD_ZERO_WORD 32'h00000000
`define HWLMD_HALF_SEL_BIT 1
`define HWLMD_BE_LOW_HALF 4'h3
`define HWLMD_BE_HIGH_HALF 4'hC
`define HWLMD_BE_WORD 4'hF
`define HWLMD_BE_NONE 4'h0
`endif

//--- hw/hwlmd_pkg.sv
package hwlmd_pkg;
	typedef enum logic [1:0] {LK_NONE, LK_HALF_S, LK_HALF_U, LK_WORD} hwlmd_kind_t;
	typedef enum logic [1:0] {ST_IDLE, ST_XLATE, ST_MEM} hwlmd_state_t;
	typedef enum logic [2:0] {
		EC_NONE, EC_MISALIGN, EC_SUPERVISOR, EC_TLB_READ,
		EC_FAST_MISS, EC_DOUBLE_MISS, EC_MPU_REGION, EC_UNHANDLED
	} hwlmd_cause_t;
endpackage : hwlmd_pkg

//--- hw/hwlmd_extend.sv
`timescale 1ns/1ps
`include "hwlmd_defs.svh"
module hwlmd_extend (
	input wire logic [31:0] rawWord,
	input wire logic [1:0] byteAddr,
	input wire hwlmd_pkg::hwlmd_kind_t kind,
	output logic [31:0] result
);
	import hwlmd_pkg::*;
	logic [15:0] half;
	// ----------------------------------------
	// halfword pick and extension
	// ----------------------------------------
	always_comb begin
		// little-endian lanes; bit 0 of the address is ignored
		half = byteAddr[`HWLMD_HALF_SEL_BIT] ? rawWord[31:16] : rawWord[15:0];
		unique case (kind)
			LK_HALF_S: result = {{16{half[15]}}, half};
			LK_HALF_U: result = {`HWLMD_ZERO_HALF, half};
			LK_WORD: result = rawWord;
			LK_NONE: result = `HWLMD_ZERO_WORD;
		endcase
	end
endmodule : hwlmd_extend

//--- hw/hwlmd_decode.sv
// Summary of operation
// - load address is base operand plus sign-extended 16-bit immediate
// - signed halfword loads write the halfword sign-extended to 32 bits
// - unsigned halfword loads write the halfword with upper 16 bits zero
// - with a data cache, ordinary loads read through the cache
// - with a data cache, I/O loads bypass it and use the data bus
// - without a data cache, I/O loads act as ordinary loads
// - loads raise alignment, supervisor, translation and region faults
// - opcodes 0x0f and 0x2f decode as signed halfword loads
// - opcodes 0x17 and 0x37 decode as word loads
// - field A selects base register; field B is destination register, field C for register move
// - register move is add of source and zero register
// - high move puts immediate in upper half, lower half zero
// - high move is OR-high-immediate with zero register source
// - signed move is add-immediate to zero register, sign-extended
`timescale 1ns/1ps
`include "hwlmd_defs.svh"
module hwlmd_decode #(
	parameter bit HAS_DCACHE = 1'b1,
	parameter bit CHECK_ALIGN = 1'b1,
	parameter logic [5:0] ADDI_OPCODE = 6'h04,
	parameter logic [5:0] ORHI_OPCODE = 6'h34,
	parameter logic [5:0] RTYPE_OPCODE = 6'h3A,
	parameter logic [5:0] ADD_OPX = 6'h31
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instValid,
	input wire logic [31:0] instWord,
	input wire logic [31:0] baseOperandReg,
	input wire logic [31:0] destOperandReg,
	output logic instReady,
	output logic xlateReq,
	output logic [31:0] xlateAddr,
	input wire logic xlateDone,
	input wire logic faultSupervisor,
	input wire logic faultTlbRead,
	input wire logic faultFastMiss,
	input wire logic faultDoubleMiss,
	input wire logic faultMpuRegion,
	output logic cacheReq,
	output logic [31:0] cacheAddr,
	input wire logic cacheAck,
	input wire logic [31:0] cacheData,
	output logic busRead,
	output logic [31:0] busAddr,
	output logic [3:0] busByteEnable,
	input wire logic busAck,
	input wire logic [31:0] busData,
	output logic wbValid,
	output logic [4:0] wbIndex,
	output logic [31:0] wbData,
	output logic excValid,
	output hwlmd_pkg::hwlmd_cause_t excCause,
	output logic [31:0] excAddr
);
	import hwlmd_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction : sext16

	function automatic hwlmd_kind_t loadKind(input logic [5:0] op);
		unique case (op)
			`HWLMD_OP_HALF_S, `HWLMD_OP_HALF_S_IO: loadKind = LK_HALF_S;
			`HWLMD_OP_HALF_U, `HWLMD_OP_HALF_U_IO: loadKind = LK_HALF_U;
			`HWLMD_OP_WORD, `HWLMD_OP_WORD_IO: loadKind = LK_WORD;
			default: loadKind = LK_NONE;
		endcase
	endfunction : loadKind

	function automatic logic isIoOp(input logic [5:0] op);
		isIoOp = (op == `HWLMD_OP_HALF_S_IO) || (op == `HWLMD_OP_HALF_U_IO) ||
			(op == `HWLMD_OP_WORD_IO);
	endfunction : isIoOp

	function automatic logic misaligned(input hwlmd_kind_t k, input logic [31:0] a);
		unique case (k)
			LK_HALF_S, LK_HALF_U: misaligned = a[0];
			LK_WORD: misaligned = |a[1:0];
			LK_NONE: misaligned = 1'b0;
		endcase
	endfunction : misaligned

	// ----------------------------------------
	// field split
	// ----------------------------------------
	logic [5:0] opcode;
	logic [5:0] opx;
	logic [4:0] fieldA;
	logic [4:0] fieldB;
	logic [4:0] fieldC;
	logic [15:0] immField16;
	logic [31:0] effAddr;
	logic accept;
	hwlmd_kind_t decKind;

	assign opcode = instWord[`HWLMD_OP_MSB:`HWLMD_OP_LSB];
	assign opx = instWord[`HWLMD_OPX_MSB:`HWLMD_OPX_LSB];
	assign fieldA = instWord[`HWLMD_A_MSB:`HWLMD_A_LSB];
	assign fieldB = instWord[`HWLMD_B_MSB:`HWLMD_B_LSB];
	assign fieldC = instWord[`HWLMD_C_MSB:`HWLMD_C_LSB];
	assign immField16 = instWord[`HWLMD_IMM_MSB:`HWLMD_IMM_LSB];
	assign effAddr = baseOperandReg + sext16(immField16);
	assign decKind = loadKind(opcode);

	// ----------------------------------------
	// state
	// ----------------------------------------
	hwlmd_state_t state, next_state;
	hwlmd_kind_t kind, next_kind;
	logic ioVariant, next_ioVariant;
	logic useCache, next_useCache;
	logic [31:0] addr, next_addr;
	logic [4:0] dest, next_dest;
	logic next_xlateReq, next_cacheReq, next_busRead;
	logic next_wbValid, next_excValid;
	logic [4:0] next_wbIndex;
	logic [31:0] next_wbData, next_excAddr;
	hwlmd_cause_t next_excCause;
	logic [31:0] memWord;
	logic [31:0] loadResult;
	logic memAck;

	assign instReady = (state == ST_IDLE);
	assign accept = instValid && instReady;
	assign xlateAddr = addr;
	assign cacheAddr = addr;
	assign busAddr = addr;
	assign memWord = useCache ? cacheData : busData;
	assign memAck = useCache ? cacheAck : busAck;

	always_comb begin
		unique case (kind)
			LK_WORD: busByteEnable = `HWLMD_BE_WORD;
			LK_HALF_S, LK_HALF_U: busByteEnable = addr[`HWLMD_HALF_SEL_BIT] ?
				`HWLMD_BE_HIGH_HALF : `HWLMD_BE_LOW_HALF;
			LK_NONE: busByteEnable = `HWLMD_BE_NONE;
		endcase
	end

	hwlmd_extend u_extend (
		.rawWord(memWord),
		.byteAddr(addr[1:0]),
		.kind(kind),
		.result(loadResult)
	);

	// ----------------------------------------
	// next-value logic
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_ioVariant = ioVariant;
		next_useCache = useCache;
		next_addr = addr;
		next_dest = dest;
		next_xlateReq = xlateReq;
		next_cacheReq = cacheReq;
		next_busRead = busRead;
		next_wbValid = 1'b0;
		next_wbIndex = wbIndex;
		next_wbData = wbData;
		next_excValid = 1'b0;
		next_excCause = excCause;
		next_excAddr = excAddr;
		unique case (state)
			ST_IDLE: begin
				if (accept) begin
					next_kind = decKind;
					next_ioVariant = isIoOp(opcode);
					if (decKind != LK_NONE) begin
						next_addr = effAddr;
						next_dest = fieldB;
						// misaligned addresses are the caller's fault; trapping beats silent garbage
						if (CHECK_ALIGN && misaligned(decKind, effAddr)) begin
							next_excValid = 1'b1;
							next_excCause = EC_MISALIGN;
							next_excAddr = effAddr;
						end else begin
							next_xlateReq = 1'b1;
							next_state = ST_XLATE;
						end
					end else if (opcode == RTYPE_OPCODE && opx == ADD_OPX) begin
						// a move is this add with the zero register as second source
						next_wbValid = (fieldC != `HWLMD_ZERO_REG);
						next_wbIndex = fieldC;
						next_wbData = baseOperandReg + destOperandReg;
					end else if (opcode == ORHI_OPCODE) begin
						next_wbValid = (fieldB != `HWLMD_ZERO_REG);
						next_wbIndex = fieldB;
						next_wbData = baseOperandReg | {immField16, `HWLMD_ZERO_HALF};
					end else if (opcode == ADDI_OPCODE) begin
						next_wbValid = (fieldB != `HWLMD_ZERO_REG);
						next_wbIndex = fieldB;
						next_wbData = baseOperandReg + sext16(immField16);
					end else begin
						next_excValid = 1'b1;
						next_excCause = EC_UNHANDLED;
						next_excAddr = `HWLMD_ZERO_WORD;
					end
				end
			end
			ST_XLATE: begin
				if (xlateDone) begin
					next_xlateReq = 1'b0;
					next_excAddr = addr;
					next_excValid = faultSupervisor || faultTlbRead || faultFastMiss ||
						faultDoubleMiss || faultMpuRegion;
					if (faultSupervisor) begin
						next_excCause = EC_SUPERVISOR;
					end else if (faultTlbRead) begin
						next_excCause = EC_TLB_READ;
					end else if (faultFastMiss) begin
						next_excCause = EC_FAST_MISS;
					end else if (faultDoubleMiss) begin
						next_excCause = EC_DOUBLE_MISS;
					end else if (faultMpuRegion) begin
						next_excCause = EC_MPU_REGION;
					end
					if (next_excValid) begin
						next_state = ST_IDLE;
					end else begin
						// io loads never touch the cache; without one all loads use the bus
						next_useCache = HAS_DCACHE && !ioVariant;
						next_cacheReq = HAS_DCACHE && !ioVariant;
						next_busRead = !(HAS_DCACHE && !ioVariant);
						next_state = ST_MEM;
					end
				end
			end
			ST_MEM: begin
				if (memAck) begin
					next_cacheReq = 1'b0;
					next_busRead = 1'b0;
					next_wbValid = (dest != `HWLMD_ZERO_REG);
					next_wbIndex = dest;
					next_wbData = loadResult;
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			kind <= LK_NONE;
			ioVariant <= 1'b0;
			useCache <= 1'b0;
			addr <= `HWLMD_ZERO_WORD;
			dest <= `HWLMD_ZERO_REG;
			xlateReq <= 1'b0;
			cacheReq <= 1'b0;
			busRead <= 1'b0;
			wbValid <= 1'b0;
			wbIndex <= `HWLMD_ZERO_REG;
			wbData <= `HWLMD_ZERO_WORD;
			excValid <= 1'b0;
			excCause <= EC_NONE;
			excAddr <= `HWLMD_ZERO_WORD;
		end else begin
			state <= next_state;
			kind <= next_kind;
			ioVariant <= next_ioVariant;
			useCache <= next_useCache;
			addr <= next_addr;
			dest <= next_dest;
			xlateReq <= next_xlateReq;
			cacheReq <= next_cacheReq;
			busRead <= next_busRead;
			wbValid <= next_wbValid;
			wbIndex <= next_wbIndex;
			wbData <= next_wbData;
			excValid <= next_excValid;
			excCause <= next_excCause;
			excAddr <= next_excAddr;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_EA_FORM: assert property (
		$rose(xlateReq) |-> xlateAddr == $past(baseOperandReg) +
			sext16($past(instWord[`HWLMD_IMM_MSB:`HWLMD_IMM_LSB])))
		else $error("load address not base plus immediate");
	AST_HALF_SIGN: assert property (
		wbValid && $past(state) == ST_MEM && kind == LK_HALF_S |->
			wbData[31:16] == {16{wbData[15]}})
		else $error("signed halfword not sign extended");
	AST_HALF_ZERO: assert property (
		wbValid && $past(state) == ST_MEM && kind == LK_HALF_U |->
			wbData[31:16] == `HWLMD_ZERO_HALF)
		else $error("unsigned halfword upper half not zero");
	AST_IO_BYPASS: assert property (
		busRead || cacheReq |-> cacheReq == (HAS_DCACHE && !ioVariant) && busRead != cacheReq)
		else $error("wrong path for load");
	AST_MISALIGN: assert property (
		excValid && excCause == EC_MISALIGN |-> misaligned(kind, excAddr) && !xlateReq)
		else $error("alignment fault without misaligned address");
	AST_DECODE_WORD: assert property (
		accept && (opcode == `HWLMD_OP_WORD || opcode == `HWLMD_OP_WORD_IO) |=>
			kind == LK_WORD && ioVariant == $past(opcode[5]))
		else $error("word load decoded wrongly");
	AST_DECODE_HALF: assert property (
		accept && (opcode == `HWLMD_OP_HALF_S || opcode == `HWLMD_OP_HALF_S_IO) |=>
			kind == LK_HALF_S)
		else $error("signed halfword load decoded wrongly");
	AST_MOVHI: assert property (
		accept && opcode == ORHI_OPCODE && baseOperandReg == `HWLMD_ZERO_WORD &&
			fieldB != `HWLMD_ZERO_REG |=> wbValid && wbIndex == $past(fieldB) &&
			wbData == {$past(immField16), `HWLMD_ZERO_HALF})
		else $error("high move result wrong");
	AST_MOVI: assert property (
		accept && opcode == ADDI_OPCODE && baseOperandReg == `HWLMD_ZERO_WORD &&
			fieldB != `HWLMD_ZERO_REG |=> wbValid && wbData == sext16($past(immField16)))
		else $error("signed move result wrong");
	AST_MEM_HOLD: assert property (
		busRead && !busAck |=> busRead && $stable(busAddr) && $stable(busByteEnable))
		else $error("bus read dropped before answer");
endmodule : hwlmd_decode

//--- verification/hwlmd_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far side: translation, data cache, data bus
// ----------------------------------------
module hwlmd_mem_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] delay,
	input wire logic [4:0] faultMask,
	input wire logic xlateReq,
	output logic xlateDone,
	output logic faultSupervisor,
	output logic faultTlbRead,
	output logic faultFastMiss,
	output logic faultDoubleMiss,
	output logic faultMpuRegion,
	input wire logic cacheReq,
	input wire logic [31:0] cacheAddr,
	output logic cacheAck,
	output logic [31:0] cacheData,
	input wire logic busRead,
	input wire logic [31:0] busAddr,
	output logic busAck,
	output logic [31:0] busData,
	output logic [7:0] cacheCount,
	output logic [7:0] busCount
);
	logic [31:0] noise = 32'h00000001;
	logic [3:0] xCnt, cCnt, bCnt;
	logic [31:0] cWord, bWord;
	// lanes differ between cache and bus so a wrong path shows in the data
	assign cWord = {cacheAddr[15:2], 2'h0, ~cacheAddr[15:2], 2'h3};
	assign bWord = {~busAddr[15:2], 2'h3, busAddr[15:2], 2'h0};
	// no kinder than real parts: lines are garbage outside the answer cycle
	assign {faultSupervisor, faultTlbRead, faultFastMiss, faultDoubleMiss, faultMpuRegion} =
		xlateDone ? faultMask : noise[4:0];
	assign cacheData = cacheAck ? cWord : noise;
	assign busData = busAck ? bWord : ~noise;
	always @(posedge clk) begin
		noise <= noise * 32'h41C64E6D + 32'h00003039;
		if (sys_rst) begin
			{xCnt, cCnt, bCnt} <= 12'h000;
			{xlateDone, cacheAck, busAck} <= 3'h0;
			cacheCount <= 8'h00;
			busCount <= 8'h00;
		end else begin
			xlateDone <= xlateReq && !xlateDone && xCnt == delay;
			xCnt <= (xlateReq && !xlateDone) ? xCnt + 4'h1 : 4'h0;
			cacheAck <= cacheReq && !cacheAck && cCnt == delay;
			cCnt <= (cacheReq && !cacheAck) ? cCnt + 4'h1 : 4'h0;
			busAck <= busRead && !busAck && bCnt == delay;
			bCnt <= (busRead && !busAck) ? bCnt + 4'h1 : 4'h0;
			if (cacheReq && !cacheAck && cCnt == delay) cacheCount <= cacheCount + 8'h01;
			if (busRead && !busAck && bCnt == delay) busCount <= busCount + 8'h01;
		end
	end
endmodule : hwlmd_mem_model

//--- verification/tb.sv
`timescale 1ns/1ps
`include "hwlmd_defs.svh"
module tb;
	import hwlmd_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instValid = 1'b0;
	logic [31:0] instWord = 32'h00000000;
	logic [31:0] baseOperandReg = 32'h00000000;
	logic [31:0] destOperandReg = 32'h00000000;
	logic [3:0] delay = 4'h0;
	logic [4:0] faultMask = 5'h00;
	logic instReady, xlateReq, xlateDone, cacheReq, cacheAck, busRead, busAck;
	logic faultSupervisor, faultTlbRead, faultFastMiss, faultDoubleMiss, faultMpuRegion;
	logic wbValid, excValid;
	logic [31:0] xlateAddr, cacheAddr, cacheData, busAddr, busData, wbData, excAddr;
	logic [3:0] busByteEnable;
	logic [4:0] wbIndex;
	logic [7:0] cacheCount, busCount;
	hwlmd_cause_t excCause;
	int fails = 0;
	int numChecks = 0;
	bit hung = 1'b0;
	always #2.5 clk = ~clk;
	hwlmd_decode dut_u (.clk, .sys_rst, .instValid, .instWord, .baseOperandReg, .destOperandReg,
		.instReady, .xlateReq, .xlateAddr, .xlateDone, .faultSupervisor, .faultTlbRead,
		.faultFastMiss, .faultDoubleMiss, .faultMpuRegion, .cacheReq, .cacheAddr, .cacheAck,
		.cacheData, .busRead, .busAddr, .busByteEnable, .busAck, .busData, .wbValid, .wbIndex,
		.wbData, .excValid, .excCause, .excAddr);
	hwlmd_mem_model model_u (.clk, .sys_rst, .delay, .faultMask, .xlateReq, .xlateDone,
		.faultSupervisor, .faultTlbRead, .faultFastMiss, .faultDoubleMiss, .faultMpuRegion,
		.cacheReq, .cacheAddr, .cacheAck, .cacheData, .busRead, .busAddr, .busAck, .busData,
		.cacheCount, .busCount);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task printVerdict;
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : printVerdict
	task automatic chk(input bit ok, input string msg);
		numChecks++;
		if (!ok) begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk
	function automatic logic [31:0] iw(input logic [4:0] a, b, input logic [15:0] i,
		input logic [5:0] op);
		return {a, b, i, op};
	endfunction : iw
	// expected memory word, worked out independently of the model
	function automatic logic [31:0] mem(input logic [31:0] ea, input bit bus);
		return bus ? {~ea[15:2], 2'h3, ea[15:2], 2'h0} : {ea[15:2], 2'h0, ~ea[15:2], 2'h3};
	endfunction : mem
	function automatic logic [31:0] half(input logic [31:0] ea, input bit bus, input bit sgn);
		logic [31:0] m;
		logic [15:0] h;
		m = mem(ea, bus);
		h = ea[1] ? m[31:16] : m[15:0];
		return {{16{sgn & h[15]}}, h};
	endfunction : half
	// path: 0 no memory access, 1 cache, 2 bus
	task automatic exec(input logic [31:0] w, base, dreg, input logic [4:0] idx,
		input logic [31:0] val, input hwlmd_cause_t cause, input int path);
		logic [31:0] ea;
		logic [3:0] be;
		int c0, b0, n;
		if (hung) return;
		ea = base + {{16{w[21]}}, w[21:6]};
		be = (w[5:0] == `HWLMD_OP_WORD || w[5:0] == `HWLMD_OP_WORD_IO) ? 4'hF :
			(ea[1] ? 4'hC : 4'h3);
		c0 = cacheCount;
		b0 = busCount;
		n = 0;
		while (instReady !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 40) begin
			hung = 1'b1;
			fails++;
			$display("Error at %0t: never ready", $time);
			return;
		end
		@(posedge clk);
		instValid <= 1'b1;
		instWord <= w;
		baseOperandReg <= base;
		destOperandReg <= dreg;
		@(posedge clk);
		instValid <= 1'b0;
		for (n = 0; n < 40; n++) begin
			#1;
			if (wbValid === 1'b1 || excValid === 1'b1) break;
			if (xlateReq === 1'b1) chk(xlateAddr === ea, "effective address");
			if (cacheReq === 1'b1 || busRead === 1'b1) chk(cacheAddr === ea && busAddr === ea,
				"memory address");
			if (busRead === 1'b1) chk(busByteEnable === be, "byte enables");
			@(posedge clk);
		end
		if (n == 40) begin
			hung = 1'b1;
			fails++;
			$display("Error at %0t: no answer", $time);
			return;
		end
		if (cause == EC_NONE) chk(wbValid === 1'b1 && wbIndex === idx && wbData === val,
			"wb");
		else chk(excValid === 1'b1 && excCause === cause &&
			excAddr === (cause == EC_UNHANDLED ? 32'h00000000 : ea), "exception");
		chk(cacheCount - c0 == (path == 1) && busCount - b0 == (path == 2),
			"access path");
	endtask : exec
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic testHalf;
		logic [31:0] b;
		b = 32'h10009000;
		delay <= 4'h0;
		exec(iw(5'h03, 5'h09, 16'hF004, `HWLMD_OP_HALF_S), b, 0, 5'h09,
			half(32'h10008004, 0, 1), EC_NONE, 1);
		exec(iw(5'h03, 5'h0A, 16'hF006, `HWLMD_OP_HALF_S), b, 0, 5'h0A,
			half(32'h10008006, 0, 1), EC_NONE, 1);
		exec(iw(5'h04, 5'h0B, 16'hF004, `HWLMD_OP_HALF_S_IO), b, 0, 5'h0B,
			half(32'h10008004, 1, 1), EC_NONE, 2);
		exec(iw(5'h05, 5'h0C, 16'hF006, `HWLMD_OP_HALF_U), b, 0, 5'h0C,
			half(32'h10008006, 0, 0), EC_NONE, 1);
		exec(iw(5'h06, 5'h0D, 16'hF006, `HWLMD_OP_HALF_U_IO), b, 0, 5'h0D,
			half(32'h10008006, 1, 0), EC_NONE, 2);
		$display("test halfword loads done");
	endtask : testHalf
	task automatic testWord;
		delay <= 4'h5;
		exec(iw(5'h1F, 5'h01, 16'hFFFC, `HWLMD_OP_WORD), 32'h20000008, 0, 5'h01,
			mem(32'h20000004, 0), EC_NONE, 1);
		exec(iw(5'h02, 5'h1E, 16'h7FFC, `HWLMD_OP_WORD_IO), 32'h20000008, 0, 5'h1E,
			mem(32'h20008004, 1), EC_NONE, 2);
		$display("test word loads done");
	endtask : testWord
	task automatic testMoves;
		exec({5'h03, 5'h00, 5'h07, 6'h31, 5'h00, 6'h3A}, 32'h1234ABCD, 0, 5'h07,
			32'h1234ABCD, EC_NONE, 0);
		exec(iw(5'h00, 5'h06, 16'h8000, 6'h34), 0, 0, 5'h06, 32'h80000000, EC_NONE, 0);
		exec(iw(5'h00, 5'h06, 16'hFFFF, 6'h34), 0, 0, 5'h06, 32'hFFFF0000, EC_NONE, 0);
		exec(iw(5'h00, 5'h05, 16'h8000, 6'h04), 0, 0, 5'h05, 32'hFFFF8000, EC_NONE, 0);
		exec(iw(5'h00, 5'h05, 16'h7FFF, 6'h04), 0, 0, 5'h05, 32'h00007FFF, EC_NONE, 0);
		$display("test moves done");
	endtask : testMoves
	task automatic testFaults;
		hwlmd_cause_t tbl[5] = '{EC_SUPERVISOR, EC_TLB_READ, EC_FAST_MISS, EC_DOUBLE_MISS,
			EC_MPU_REGION};
		delay <= 4'h2;
		for (int k = 0; k < 5; k++) begin
			faultMask <= 5'h10 >> k;
			exec(iw(5'h01, 5'h02, 16'h0010, `HWLMD_OP_WORD), 32'h00000100, 0, 5'h02, 0,
				tbl[k], 0);
		end
		faultMask <= 5'h1F;
		exec(iw(5'h01, 5'h02, 16'h0010, `HWLMD_OP_HALF_U), 32'h00000100, 0, 5'h02, 0,
			EC_SUPERVISOR, 0);
		faultMask <= 5'h03;
		exec(iw(5'h01, 5'h02, 16'h0010, `HWLMD_OP_HALF_S), 32'h00000100, 0, 5'h02, 0,
			EC_DOUBLE_MISS, 0);
		faultMask <= 5'h00;
		exec(iw(5'h01, 5'h02, 16'h0005, `HWLMD_OP_HALF_S_IO), 32'h00000100, 0, 5'h02, 0,
			EC_MISALIGN, 0);
		exec(iw(5'h01, 5'h02, 16'h0006, `HWLMD_OP_WORD_IO), 32'h00000100, 0, 5'h02, 0,
			EC_MISALIGN, 0);
		exec(iw(5'h01, 5'h02, 16'h0000, 6'h3F), 32'h00000100, 0, 5'h02, 0,
			EC_UNHANDLED, 0);
		$display("test faults done");
	endtask : testFaults
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk(instReady === 1'b1 && wbValid === 1'b0 && xlateReq === 1'b0, "reset state");
		testHalf();
		testWord();
		testMoves();
		testFaults();
		printVerdict();
	end
endmodule : tb
